/* File: verilog/dsside_serial_path.sv */
// disk serial data path: word serializer, sync detect, sector id compare, check sum, status
//
// Summary of operation
// - read turns drive bits into 16-bit words; write turns words into bits.
// - word-clock load pulse moves write buffer into shifter; shifted out, retimed by clock A.
// - read bits shift in on clock B; bit-ring pulse latches the word.
// - processor read of the data port puts the read buffer on the bus.
// - sync byte 19H precedes fields; option uses D9H for data fields.
// - during read, active-low sync detect asserts when shifter shows 19H.
// - sync detect plus next clock B edge sets sync found, starting word clock.
// - compared id is flags, cylinder, sector and head, 32 bits.
// - id compare starts on the clock B edge that sets sync found, target shifted out bitwise on clock B.
// - any differing bit drives id mismatch low; match keeps it high.
// - id and check mismatches ORed and latched as status bit 6.
// - writes append a four-byte polynomial check sum to the field.
// - write data gated by delayed strobe; at check time the sum is sent instead.
// - read feeds generator and shifter; at check time difference goes into shifter.
// - zero difference means valid; nonzero difference is the error syndrome.
// - status port read asserts its read decode and drives the status word.
// - status bits C-8, 4 and 2-0 follow expansion bus lines directly; bit 3 ORs its line with the data sync flag.
// - with the option, the D9H data-field sync byte after an address mark sets status bit 3.
`timescale 1ns/1ps
`default_nettype none
module dsside_serial_path
    import dsside_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [15:0] localAddr,
    input wire logic localRead,
    input wire logic localWrite,
    input wire logic [15:0] boardDataBus,
    output logic [15:0] internalDataBus,
    output logic statusMainReadDecodeN,
    output logic statusOptionReadDecodeN,
    output logic dataPortReadDecodeN,
    input wire logic writeTransferStrobeN,
    input wire logic writeTransferDelayed,
    input wire logic eccTimeN,
    input wire logic endTime,
    input wire logic readGate,
    input wire logic idField,
    input wire logic addressMarkFound,
    input wire logic altSyncOption,
    input wire logic rwClkA,
    input wire logic rwClkB,
    input wire logic serialReadData,
    input wire logic [4:0] driveStatusLines,
    input wire logic [2:0] optionStatusLines,
    input wire logic [9:0] expansionMainLines,
    input wire logic [4:0] expansionOptionLines,
    output logic serialWriteLine,
    output logic syncByteDetectN,
    output logic syncFound,
    output logic idMismatchN,
    output logic checkMismatchN,
    output logic combinedMismatchN,
    output logic latchedMismatch,
    output logic writeBufferReady,
    output logic readWordReady,
    output logic shiftLoadPulse,
    output logic wordLatchPulse
);
    localparam int PIN_W = 26;

    function automatic logic portHit(input logic [15:0] addr, input logic [15:0] offset);
        portHit = (addr == offset);
    endfunction : portHit

    function automatic logic [31:0] eccStep(input logic [31:0] ecc, input logic bitIn);
        logic fb;
        fb = bitIn ^ ecc[31];
        eccStep = {ecc[30:0], 1'b0} ^ (fb ? ECC_POLY : ECC_RESET);
    endfunction : eccStep

    // pin synchronisers; only pinSync2 and later are read by logic
    logic [PIN_W-1:0] pinSync1;
    logic [PIN_W-1:0] pinSync2;
    logic clkBPrev;
    logic clkAPrev;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pinSync1 <= '0;
            pinSync2 <= '0;
            clkBPrev <= 1'b0;
            clkAPrev <= 1'b0;
        end
        else if (ce)
        begin
            pinSync1 <= {rwClkA, rwClkB, serialReadData, driveStatusLines, optionStatusLines,
                         expansionMainLines, expansionOptionLines};
            pinSync2 <= pinSync1;
            clkBPrev <= pinSync2[24];
            clkAPrev <= pinSync2[25];
        end
    end

    logic bitEdge;
    logic aEdge;
    logic rdBit;
    logic [4:0] drvSt;
    logic [2:0] optSt;
    logic [9:0] expMain;
    logic [4:0] expOpt;
    assign bitEdge = pinSync2[24] && !clkBPrev;
    assign aEdge = pinSync2[25] && !clkAPrev;
    assign rdBit = pinSync2[23];
    assign drvSt = pinSync2[22:18];
    assign optSt = pinSync2[17:15];
    assign expMain = pinSync2[14:5];
    assign expOpt = pinSync2[4:0];

    // processor port decode
    logic mainRead;
    logic optionRead;
    logic dataRead;
    logic dataWrite;
    assign mainRead = localRead && portHit(localAddr, DRIVE_BOARD_STATUS_MAIN);
    assign optionRead = localRead && portHit(localAddr, DRIVE_OPTION_STATUS);
    assign dataRead = localRead && portHit(localAddr, SERIAL_DATA_PORT);
    assign dataWrite = localWrite && portHit(localAddr, SERIAL_DATA_PORT);
    assign statusMainReadDecodeN = !mainRead;
    assign statusOptionReadDecodeN = !optionRead;
    assign dataPortReadDecodeN = !dataRead;

    // outgoing word buffer
    logic [15:0] bufWord;
    logic bufValid;
    logic bufPop;

    dsside_word_buffer #(
        .WIDTH(WORD_BITS),
        .DEPTH(BUFFER_DEPTH)
    ) writeBuffer (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .inValid(dataWrite && !writeTransferStrobeN),
        .inReady(writeBufferReady),
        .inData(boardDataBus),
        .outValid(bufValid),
        .outReady(bufPop),
        .outData(bufWord)
    );

    // serial state
    dsside_phase_type phase;
    dsside_phase_type next_phase;
    logic [15:0] shiftReg;
    logic [15:0] next_shiftReg;
    logic [3:0] bitCount;
    logic [3:0] next_bitCount;
    logic [31:0] eccReg;
    logic [31:0] next_eccReg;
    logic [31:0] idShift;
    logic [31:0] next_idShift;
    logic [5:0] idBitsLeft;
    logic [5:0] next_idBitsLeft;
    logic idMiss;
    logic next_idMiss;
    logic eccMiss;
    logic next_eccMiss;
    logic txBit;
    logic next_txBit;
    logic next_serialWriteLine;
    logic [15:0] readBuffer;
    logic [15:0] next_readBuffer;
    logic next_readWordReady;
    logic next_latchedMismatch;
    logic dataSyncFlag;
    logic next_dataSyncFlag;
    logic next_shiftLoadPulse;
    logic next_wordLatchPulse;
    logic [15:0] targetHigh;
    logic [15:0] next_targetHigh;
    logic [15:0] targetLow;
    logic [15:0] next_targetLow;
    logic [15:0] next_internalDataBus;

    logic eccTime;
    logic syncHit;
    logic altHit;
    logic syncDetect;
    assign eccTime = !eccTimeN;
    assign syncHit = (shiftReg[7:0] == SYNC_BYTE);
    assign altHit = altSyncOption && addressMarkFound && !idField
                    && (shiftReg[7:0] == SYNC_BYTE_ALT);
    assign syncDetect = (phase == PHASE_HUNT) && (syncHit || altHit);
    assign syncByteDetectN = !syncDetect;
    assign syncFound = (phase == PHASE_READ);
    assign idMismatchN = !idMiss;
    assign checkMismatchN = !eccMiss;
    assign combinedMismatchN = !(idMiss || eccMiss);

    always_comb
    begin
        logic [15:0] word;
        logic [31:0] eccNow;
        logic inBit;
        logic outBit;
        logic takeRead;
        word = WORD_RESET;
        eccNow = eccReg;
        inBit = 1'b0;
        outBit = 1'b0;
        takeRead = 1'b0;
        next_phase = phase;
        next_shiftReg = shiftReg;
        next_bitCount = bitCount;
        next_eccReg = eccReg;
        next_idShift = idShift;
        next_idBitsLeft = idBitsLeft;
        next_idMiss = idMiss;
        next_eccMiss = eccMiss;
        next_txBit = txBit;
        next_readBuffer = readBuffer;
        next_readWordReady = readWordReady && !dataRead;
        next_latchedMismatch = latchedMismatch;
        next_dataSyncFlag = dataSyncFlag;
        next_shiftLoadPulse = 1'b0;
        next_wordLatchPulse = 1'b0;
        bufPop = 1'b0;
        case (phase)
            PHASE_IDLE:
            begin
                next_bitCount = COUNT_RESET;
                if (!writeTransferStrobeN)
                begin
                    next_phase = PHASE_WRITE;
                    next_eccReg = ECC_RESET;
                end
                else if (readGate)
                begin
                    next_phase = PHASE_HUNT;
                end
            end
            PHASE_HUNT:
            begin
                if (!readGate)
                begin
                    next_phase = PHASE_IDLE;
                end
                else if (bitEdge && syncDetect)
                begin
                    next_phase = PHASE_READ;
                    eccNow = ECC_RESET;
                    next_idShift = {targetHigh, targetLow};
                    next_idBitsLeft = idField ? ID_BIT_COUNT : 6'h00;
                    next_idMiss = 1'b0;
                    next_eccMiss = 1'b0;
                    next_bitCount = COUNT_RESET;
                    next_dataSyncFlag = altHit;
                    takeRead = 1'b1;
                end
                else if (bitEdge)
                begin
                    next_shiftReg = {shiftReg[14:0], rdBit};
                end
            end
            PHASE_READ:
            begin
                takeRead = bitEdge;
            end
            PHASE_WRITE:
            begin
                if (bitEdge)
                begin
                    if (bitCount == COUNT_RESET)
                    begin
                        word = bufValid ? bufWord : WORD_RESET;
                        bufPop = bufValid;
                        next_shiftLoadPulse = 1'b1;
                        outBit = word[15];
                        next_shiftReg = {word[14:0], 1'b0};
                    end
                    else
                    begin
                        outBit = shiftReg[15];
                        next_shiftReg = {shiftReg[14:0], 1'b0};
                    end
                    next_bitCount = 4'(bitCount + 1'b1);
                    if (writeTransferDelayed)
                    begin
                        next_txBit = outBit;
                        next_eccReg = eccStep(eccReg, outBit);
                    end
                    else if (eccTime)
                    begin
                        next_txBit = eccReg[31];
                        next_eccReg = {eccReg[30:0], 1'b0};
                    end
                    else
                    begin
                        next_txBit = 1'b0;
                    end
                end
                if (endTime)
                begin
                    next_phase = PHASE_IDLE;
                end
            end
            default:
            begin
                next_phase = PHASE_IDLE;
            end
        endcase

        if (takeRead)
        begin
            if (eccTime)
            begin
                inBit = rdBit ^ eccNow[31];
                next_eccReg = {eccNow[30:0], 1'b0};
                next_eccMiss = next_eccMiss || inBit;
            end
            else
            begin
                inBit = rdBit;
                next_eccReg = eccStep(eccNow, rdBit);
            end
            next_shiftReg = {shiftReg[14:0], inBit};
            if (next_idBitsLeft != 6'h00)
            begin
                next_idMiss = next_idMiss || (rdBit != next_idShift[31]);
                next_idShift = {next_idShift[30:0], 1'b0};
                next_idBitsLeft = 6'(next_idBitsLeft - 1'b1);
            end
            next_bitCount = 4'(next_bitCount + 1'b1);
            if (next_bitCount == COUNT_RESET)
            begin
                next_readBuffer = next_shiftReg;
                next_readWordReady = 1'b1;
                next_wordLatchPulse = 1'b1;
            end
        end
        if (phase == PHASE_READ && endTime)
        begin
            next_phase = PHASE_IDLE;
            next_latchedMismatch = next_idMiss || next_eccMiss;
        end
        next_serialWriteLine = aEdge ? txBit : serialWriteLine;

        next_targetHigh = (localWrite && portHit(localAddr, TARGET_ID_HIGH))
                          ? boardDataBus : targetHigh;
        next_targetLow = (localWrite && portHit(localAddr, TARGET_ID_LOW))
                         ? boardDataBus : targetLow;
        next_internalDataBus = WORD_RESET;
        if (mainRead)
        begin
            next_internalDataBus = {drvSt[4], drvSt[3], drvSt[2], expMain[9:5],
                                    drvSt[1], latchedMismatch, drvSt[0], expMain[4:0]};
            next_internalDataBus[STAT_DATA_SYNC] = expMain[3] || dataSyncFlag;
            next_internalDataBus[STAT_MISMATCH] = latchedMismatch;
        end
        else if (optionRead)
        begin
            next_internalDataBus = {8'h00, optSt, expOpt};
        end
        else if (dataRead)
        begin
            next_internalDataBus = readBuffer;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            phase <= PHASE_IDLE;
            shiftReg <= WORD_RESET;
            bitCount <= COUNT_RESET;
            eccReg <= ECC_RESET;
            idShift <= ECC_RESET;
            idBitsLeft <= 6'h00;
            idMiss <= 1'b0;
            eccMiss <= 1'b0;
            txBit <= 1'b0;
            serialWriteLine <= 1'b0;
            readBuffer <= WORD_RESET;
            readWordReady <= 1'b0;
            latchedMismatch <= 1'b0;
            dataSyncFlag <= 1'b0;
            shiftLoadPulse <= 1'b0;
            wordLatchPulse <= 1'b0;
            targetHigh <= WORD_RESET;
            targetLow <= WORD_RESET;
            internalDataBus <= WORD_RESET;
        end
        else if (ce)
        begin
            phase <= next_phase;
            shiftReg <= next_shiftReg;
            bitCount <= next_bitCount;
            eccReg <= next_eccReg;
            idShift <= next_idShift;
            idBitsLeft <= next_idBitsLeft;
            idMiss <= next_idMiss;
            eccMiss <= next_eccMiss;
            txBit <= next_txBit;
            serialWriteLine <= next_serialWriteLine;
            readBuffer <= next_readBuffer;
            readWordReady <= next_readWordReady;
            latchedMismatch <= next_latchedMismatch;
            dataSyncFlag <= next_dataSyncFlag;
            shiftLoadPulse <= next_shiftLoadPulse;
            wordLatchPulse <= next_wordLatchPulse;
            targetHigh <= next_targetHigh;
            targetLow <= next_targetLow;
            internalDataBus <= next_internalDataBus;
        end
    end
endmodule : dsside_serial_path
`default_nettype wire

/* File: verilog/dsside_pkg.sv */
// constants for the disk serial data path: port map, sync patterns, field sizes
package dsside_pkg;
    localparam logic [15:0] DRIVE_BOARD_STATUS_MAIN = 16'h8000;
    localparam logic [15:0] DRIVE_OPTION_STATUS = 16'h8008;
    localparam logic [15:0] SERIAL_DATA_PORT = 16'h8028;
    localparam logic [15:0] TARGET_ID_HIGH = 16'h8030;
    localparam logic [15:0] TARGET_ID_LOW = 16'h8038;

    localparam int WORD_BITS = 16;
    localparam int ID_BITS = 32;
    localparam int ECC_BITS = 32;
    localparam int BUFFER_DEPTH = 2;

    localparam logic [7:0] SYNC_BYTE = 8'h19;
    localparam logic [7:0] SYNC_BYTE_ALT = 8'hD9;
    // check polynomial taps (plain default, x^32 implied)
    localparam logic [31:0] ECC_POLY = 32'h0000_8005;

    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam logic [5:0] ID_BIT_COUNT = 6'h20;

    // bit positions in the main status word
    localparam int STAT_INDEX = 15;
    localparam int STAT_DRIVE_REQ = 14;
    localparam int STAT_ILLEGAL = 13;
    localparam int STAT_TIMEOUT = 7;
    localparam int STAT_MISMATCH = 6;
    localparam int STAT_BUS_ACK = 5;
    localparam int STAT_DATA_SYNC = 3;

    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [31:0] ECC_RESET = 32'h0000_0000;
    localparam logic [3:0] COUNT_RESET = 4'h0;

    typedef enum logic [1:0] {
        PHASE_IDLE,
        PHASE_HUNT,
        PHASE_READ,
        PHASE_WRITE
    } dsside_phase_type;
endpackage : dsside_pkg

/* File: verilog/dsside_word_buffer.sv */
// small word buffer with valid/ready on both sides and registered storage
`timescale 1ns/1ps
`default_nettype none
module dsside_word_buffer
    import dsside_pkg::*;
#(
    parameter int WIDTH = WORD_BITS,
    parameter int DEPTH = BUFFER_DEPTH
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic [PW-1:0] next_wrPtr;
    logic [PW-1:0] next_rdPtr;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    assign inReady = (count != CW'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb
    begin
        next_wrPtr = push ? bump(wrPtr) : wrPtr;
        next_rdPtr = pop ? bump(rdPtr) : rdPtr;
        next_count = count;
        if (push && !pop)
        begin
            next_count = CW'(count + 1'b1);
        end
        else if (pop && !push)
        begin
            next_count = CW'(count - 1'b1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else if (ce)
        begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
            if (push)
            begin
                mem[wrPtr] <= inData;
            end
        end
    end
endmodule : dsside_word_buffer
`default_nettype wire

/* File: verif/dsside_serial_path_asserts.sv */
// port checker for the disk serial data path
`timescale 1ns/1ps
`default_nettype none
module dsside_serial_path_asserts
    import dsside_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [15:0] localAddr,
    input wire logic localRead,
    input wire logic [15:0] internalDataBus,
    input wire logic statusMainReadDecodeN,
    input wire logic dataPortReadDecodeN,
    input wire logic syncByteDetectN,
    input wire logic syncFound,
    input wire logic idMismatchN,
    input wire logic checkMismatchN,
    input wire logic combinedMismatchN,
    input wire logic readWordReady,
    input wire logic shiftLoadPulse,
    input wire logic wordLatchPulse
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    AST_MAIN_DECODE: assert property (
        statusMainReadDecodeN == !(localRead && localAddr == DRIVE_BOARD_STATUS_MAIN))
        else $error("main status decode wrong");
    AST_PORT_DECODE: assert property (
        dataPortReadDecodeN == !(localRead && localAddr == SERIAL_DATA_PORT))
        else $error("data port decode wrong");
    AST_BUS_IDLE: assert property (
        ce && !localRead |=> internalDataBus == 16'h0000)
        else $error("bus not idle");
    AST_COMBINED: assert property (
        combinedMismatchN == (idMismatchN && checkMismatchN))
        else $error("combined mismatch wrong");
    AST_LATCH_PULSE: assert property (
        wordLatchPulse |-> syncFound ##1 !wordLatchPulse)
        else $error("latch pulse wrong");
    AST_LOAD_PULSE: assert property (
        shiftLoadPulse |=> !shiftLoadPulse [*8])
        else $error("load pulse repeats");
    AST_READY_SET: assert property (
        wordLatchPulse |-> ##[0:1] readWordReady)
        else $error("word ready not set");
    AST_READY_CLEAR: assert property (
        ce && localRead && localAddr == SERIAL_DATA_PORT && !wordLatchPulse
        |=> !readWordReady || wordLatchPulse)
        else $error("word ready not cleared");
    AST_SYNC_SET: assert property (
        $rose(syncFound) |-> $past(syncByteDetectN) == 1'b0)
        else $error("sync found without detect");
endmodule : dsside_serial_path_asserts
`default_nettype wire

/* File: verif/dsside_drive_model.sv */
// drive side model: bit clocks, read stream, captured write bits
`timescale 1ns/1ps
`default_nettype none
module dsside_drive_model (
    input wire logic core_clk,
    input wire logic serialWriteLine,
    output logic rwClkA,
    output logic rwClkB,
    output logic serialReadData
);
    logic busy = 1'b0;
    logic wrBits[$];
    initial
    begin
        rwClkA = 1'b0;
        rwClkB = 1'b0;
        serialReadData = 1'b0;
    end
    // released data line keeps changing so a stale bit is never trusted
    always @(negedge core_clk)
        if (!busy)
            serialReadData <= ~serialReadData;
    // bit clocks run only inside a frame, bits go out msb first
    task automatic run(input logic [63:0] bits, input int n);
        busy = 1'b1;
        for (int i = n - 1; i >= 0; i--)
        begin
            @(negedge core_clk);
            rwClkB = 1'b0;
            rwClkA = 1'b0;
            serialReadData = bits[i];
            repeat (3) @(negedge core_clk);
            rwClkB = 1'b1;
            repeat (2) @(negedge core_clk);
            wrBits.push_back(serialWriteLine);
            rwClkA = 1'b1;
            repeat (2) @(negedge core_clk);
        end
        @(negedge core_clk);
        rwClkA = 1'b0;
        rwClkB = 1'b0;
        busy = 1'b0;
    endtask : run
endmodule : dsside_drive_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the disk serial data path
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dsside_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic eccTimeN = 1'b1;
    logic [15:0] localAddr = 16'h0000;
    logic localRead = 1'b0;
    logic localWrite = 1'b0;
    logic [15:0] boardDataBus = 16'h0000;
    logic writeTransferStrobeN = 1'b1;
    logic writeTransferDelayed = 1'b0;
    logic endTime = 1'b0;
    logic readGate = 1'b0;
    logic idField = 1'b0;
    logic addressMarkFound = 1'b0;
    logic altSyncOption = 1'b0;
    logic [4:0] driveStatusLines = 5'h00;
    logic [2:0] optionStatusLines = 3'h0;
    logic [9:0] expansionMainLines = 10'h000;
    logic [4:0] expansionOptionLines = 5'h00;
    wire logic rwClkA, rwClkB, serialReadData, serialWriteLine;
    wire logic syncFound, writeBufferReady, readWordReady;
    wire logic [15:0] internalDataBus;
    int mismatches = 0;
    int cmp_count = 0;
    logic rdLat = 1'b0;
    logic [15:0] expQ[$];

    dsside_serial_path dut (.core_clk, .srst, .ce, .localAddr, .localRead, .localWrite,
        .boardDataBus, .internalDataBus, .statusMainReadDecodeN(),
        .statusOptionReadDecodeN(), .dataPortReadDecodeN(), .writeTransferStrobeN,
        .eccTimeN, .writeTransferDelayed, .endTime, .readGate, .idField,
        .addressMarkFound, .altSyncOption, .rwClkA, .rwClkB, .serialReadData,
        .driveStatusLines, .optionStatusLines, .expansionMainLines, .expansionOptionLines,
        .serialWriteLine, .syncByteDetectN(), .syncFound, .idMismatchN(),
        .checkMismatchN(), .combinedMismatchN(), .latchedMismatch(), .writeBufferReady,
        .readWordReady, .shiftLoadPulse(), .wordLatchPulse());
    dsside_drive_model drv (.core_clk, .serialWriteLine, .rwClkA, .rwClkB,
        .serialReadData);

    initial forever #50 core_clk = ~core_clk;

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        expQ.push_back(e);
        @(negedge core_clk);
        localAddr = a;
        localRead = 1'b1;
        @(negedge core_clk);
        localRead = 1'b0;
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk);
        localAddr = a;
        boardDataBus = d;
        localWrite = 1'b1;
        @(negedge core_clk);
        localWrite = 1'b0;
    endtask : wr

    task automatic getWord(input logic [15:0] e);
        for (int i = 0; i < 600 && readWordReady !== 1'b1; i++)
            @(negedge core_clk);
        rd(SERIAL_DATA_PORT, e);
    endtask : getWord

    task automatic fieldEnd();
        @(negedge core_clk);
        endTime = 1'b1;
        @(negedge core_clk);
        endTime = 1'b0;
        readGate = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({15'h0000, syncFound}, 16'h0000);
    endtask : fieldEnd

    function automatic logic [15:0] mainExp(input logic b6, input logic b3);
        return {driveStatusLines[4:2], expansionMainLines[9:5], driveStatusLines[1], b6,
            driveStatusLines[0], expansionMainLines[4], expansionMainLines[3] | b3,
            expansionMainLines[2:0]};
    endfunction : mainExp

    // read data lands the cycle after the read edge
    always @(posedge core_clk) rdLat <= localRead;
    always @(negedge core_clk)
        if (rdLat)
            chk(internalDataBus, expQ.pop_front());

    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        test_done();
    end

    initial
    begin
        logic [31:0] tid;
        logic [31:0] rx;
        logic [15:0] w0;
        logic [15:0] w1;
        logic [47:0] got;
        void'($urandom(32'h9651_9de5));
        repeat (5) @(negedge core_clk);
        srst = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            driveStatusLines = 5'($urandom);
            optionStatusLines = 3'($urandom);
            expansionMainLines = 10'($urandom);
            expansionOptionLines = 5'($urandom);
            repeat (4) @(negedge core_clk);
            rd(DRIVE_BOARD_STATUS_MAIN, mainExp(1'b0, 1'b0));
            rd(DRIVE_OPTION_STATUS, {8'h00, optionStatusLines, expansionOptionLines});
        end
        rd(16'h8010, 16'h0000);
        for (int f = 0; f < 2; f++)
        begin
            tid = $urandom;
            // keep the tail byte away from both sync patterns
            tid[7] = 1'b1;
            tid[0] = 1'b0;
            rx = tid ^ (f != 0 ? 32'h0001_0000 : 32'h0000_0000);
            wr(TARGET_ID_HIGH, tid[31:16]);
            wr(TARGET_ID_LOW, tid[15:0]);
            idField = 1'b1;
            readGate = 1'b1;
            fork
                drv.run({16'h0000, 8'h00, SYNC_BYTE, rx}, 48);
                begin
                    getWord(rx[31:16]);
                    getWord(rx[15:0]);
                end
            join
            fieldEnd();
            rd(DRIVE_BOARD_STATUS_MAIN, mainExp(f != 0, 1'b0));
        end
        idField = 1'b0;
        addressMarkFound = 1'b1;
        altSyncOption = 1'b1;
        readGate = 1'b1;
        w0 = $urandom;
        fork
            drv.run({32'h0000_0000, 8'h00, SYNC_BYTE_ALT, w0}, 32);
            getWord(w0);
        join
        fieldEnd();
        addressMarkFound = 1'b0;
        rd(DRIVE_BOARD_STATUS_MAIN, mainExp(1'b0, 1'b1));
        w0 = $urandom;
        w1 = $urandom;
        writeTransferStrobeN = 1'b0;
        writeTransferDelayed = 1'b1;
        wr(SERIAL_DATA_PORT, w0);
        wr(SERIAL_DATA_PORT, w1);
        chk({15'h0000, writeBufferReady}, 16'h0000);
        wr(SERIAL_DATA_PORT, ~w0);
        drv.wrBits.delete();
        drv.run(64'h0000_0000_0000_0000, 50);
        chk({15'h0000, writeBufferReady}, 16'h0001);
        for (int i = 0; i < 48; i++)
            got[47 - i] = drv.wrBits[i + 1];
        chk(got[47:32], w0);
        chk(got[31:16], w1);
        chk(got[15:0], 16'h0000);
        writeTransferStrobeN = 1'b1;
        writeTransferDelayed = 1'b0;
        fieldEnd();
        test_done();
    end
endmodule : tb
bind dsside_serial_path dsside_serial_path_asserts chk_i (.core_clk, .srst, .ce,
    .localAddr, .localRead, .internalDataBus, .statusMainReadDecodeN,
    .dataPortReadDecodeN, .syncByteDetectN, .syncFound, .idMismatchN, .checkMismatchN,
    .combinedMismatchN, .readWordReady, .shiftLoadPulse, .wordLatchPulse);
`default_nettype wire
